// file: sim/vdcw_host_model.sv
// host bus model: issues one-cycle register and memory requests to the bank
`timescale 1ns/10ps
module vdcw_host_model (
  input  wire logic        clock_in,
  output logic             cyc_valid_out,
  output logic             cyc_io_out,
  output logic             cyc_write_out,
  output logic [31:0]      cyc_addr_out,
  output logic [7:0]       cyc_wdata_out,
  output logic             lfb_hit_out
);
  initial begin
    cyc_valid_out = 1'b0;
    cyc_io_out    = 1'b0;
    cyc_write_out = 1'b0;
    cyc_addr_out  = 32'h00000000;
    cyc_wdata_out = 8'h00;
    lfb_hit_out   = 1'b0;
  end

  // ==========================================================================
  // one request: driven after a falling edge, taken at the next rising edge
  // ==========================================================================
  task automatic cycle(input logic io, input logic wr, input logic [31:0] a,
                       input logic [7:0] d, input logic lfb);
    @(negedge clock_in);
    cyc_valid_out = 1'b1;
    cyc_io_out    = io;
    cyc_write_out = wr;
    cyc_addr_out  = a;
    cyc_wdata_out = d;
    lfb_hit_out   = lfb;
    @(negedge clock_in);
    // released lines show inverted values so stale qualifiers never match
    cyc_valid_out = 1'b0;
    cyc_io_out    = ~io;
    cyc_write_out = ~wr;
    cyc_addr_out  = ~a;
    cyc_wdata_out = ~d;
    lfb_hit_out   = ~lfb;
  endtask
endmodule

// file: sim/vdcw_regs_tb.sv
// testbench: register bank, legacy window and page window of the display cache regs
`timescale 1ns/10ps
module vdcw_regs_tb;
  localparam logic [31:0] BASE = 32'h00080000;
  logic        clock_in, rst_in, valid, io, wr, lfb;
  logic [31:0] addr;
  logic [7:0]  wdata, rd_data;
  logic        rd_valid, claim, legacy_hit, page_hit;
  logic        legacy_en, memmap_sel, packed_en, linear_en;
  logic [23:0] page_addr;
  int          n_errors, n_compared;

  vdcw_host_model host (.clock_in(clock_in), .cyc_valid_out(valid), .cyc_io_out(io),
    .cyc_write_out(wr), .cyc_addr_out(addr), .cyc_wdata_out(wdata), .lfb_hit_out(lfb));

  vdcw_regs #(.MMIO_AW(19)) dut (.clock_in(clock_in), .rst_in(rst_in), .cyc_valid_in(valid),
    .cyc_io_in(io), .cyc_write_in(wr), .cyc_addr_in(addr), .cyc_wdata_in(wdata),
    .mmio_base_in(BASE), .lfb_hit_in(lfb), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
    .claim_out(claim), .legacy_hit_out(legacy_hit), .page_hit_out(page_hit),
    .page_addr_out(page_addr), .legacy_en_out(legacy_en), .memmap_sel_out(memmap_sel),
    .packed_en_out(packed_en), .linear_en_out(linear_en));

  always #12.5 clock_in = ~clock_in;

  // ==========================================================================
  // shared helpers
  // ==========================================================================
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] place(input logic io, input logic [15:0] port);
    return io ? {16'h0000, port} : BASE + {16'h0000, port};
  endfunction

  task automatic reg_wr(input logic io, input logic [15:0] port, input logic [7:0] d);
    host.cycle(io, 1'b1, place(io, port), d, 1'b0);
    check("write claim", 32'h1, {31'h0, claim});
  endtask

  task automatic reg_rd(input logic io, input logic [15:0] port, input logic [7:0] exp);
    host.cycle(io, 1'b0, place(io, port), 8'h00, 1'b0);
    check("read valid", 32'h1, {31'h0, rd_valid});
    check("read data", {24'h0, exp}, {24'h0, rd_data});
  endtask

  task automatic gr_wr(input logic [7:0] idx, input logic [7:0] d);
    reg_wr(1'b1, vdcw_pkg::INDEX_PORT, idx);
    reg_wr(1'b1, vdcw_pkg::DATA_PORT, d);
  endtask

  task automatic gr_rd(input logic [7:0] idx, input logic [7:0] exp);
    reg_wr(1'b1, vdcw_pkg::INDEX_PORT, idx);
    reg_rd(1'b1, vdcw_pkg::DATA_PORT, exp);
  endtask

  function automatic logic in_map(input logic [1:0] m, input logic [31:0] a);
    case (m)
      vdcw_pkg::MAP_ALL:  return a >= vdcw_pkg::WIN_A_LO && a <= vdcw_pkg::WIN_ALL_HI;
      vdcw_pkg::MAP_A:    return a >= vdcw_pkg::WIN_A_LO && a <= vdcw_pkg::WIN_A_HI;
      vdcw_pkg::MAP_MONO: return a >= vdcw_pkg::WIN_MONO_LO && a <= vdcw_pkg::WIN_MONO_HI;
      default:            return a >= vdcw_pkg::WIN_COLOR_LO && a <= vdcw_pkg::WIN_ALL_HI;
    endcase
  endfunction

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_reset;
    reg_rd(1'b1, vdcw_pkg::MISC_RD_PORT, 8'h00);
    gr_rd(vdcw_pkg::IDX_ADDR_MAP, 8'h00);
    check("legacy enable", 32'h0, {31'h0, legacy_en});
    check("modes", 32'h0, {29'h0, memmap_sel, packed_en, linear_en});
  endtask

  task automatic t_index;
    // bit 4 stays hidden, so index 16h is unimplemented
    reg_wr(1'b1, vdcw_pkg::INDEX_PORT, 8'hf6);
    reg_rd(1'b1, vdcw_pkg::INDEX_PORT, 8'h06);
    reg_rd(1'b1, vdcw_pkg::DATA_PORT, 8'h00);
  endtask

  task automatic t_gfx_regs;
    gr_wr(vdcw_pkg::IDX_FRAME_MAP, 8'hff);
    gr_rd(vdcw_pkg::IDX_FRAME_MAP, 8'h0c);
    gr_wr(vdcw_pkg::IDX_ADDR_MAP, 8'hff);
    check("modes", 32'h7, {29'h0, memmap_sel, packed_en, linear_en});
    reg_rd(1'b1, vdcw_pkg::DATA_PORT, 8'h1f);
    gr_wr(8'h07, 8'hff);
    gr_rd(8'h07, 8'h00);
    gr_rd(vdcw_pkg::IDX_ADDR_MAP, 8'h1f);
    gr_wr(vdcw_pkg::IDX_ADDR_MAP, 8'h00);
    check("modes", 32'h0, {29'h0, memmap_sel, packed_en, linear_en});
  endtask

  task automatic t_misc;
    reg_wr(1'b1, vdcw_pkg::MISC_WR_PORT, 8'hff);
    check("legacy enable", 32'h1, {31'h0, legacy_en});
    reg_rd(1'b1, vdcw_pkg::MISC_RD_PORT, 8'h02);
    reg_rd(1'b1, vdcw_pkg::MISC_WR_PORT, 8'h00);
    reg_wr(1'b1, vdcw_pkg::MISC_RD_PORT, 8'h00);
    reg_rd(1'b1, vdcw_pkg::MISC_RD_PORT, 8'h02);
  endtask

  task automatic t_mmio;
    reg_rd(1'b0, vdcw_pkg::MISC_RD_PORT, 8'h02);
    reg_wr(1'b0, vdcw_pkg::INDEX_PORT, {3'h0, vdcw_pkg::IDX_PAGE_SEL});
    reg_rd(1'b1, vdcw_pkg::INDEX_PORT, 8'h01);
    reg_wr(1'b0, vdcw_pkg::DATA_PORT, 8'h5a);
    reg_rd(1'b1, vdcw_pkg::DATA_PORT, 8'h5a);
  endtask

  task automatic t_legacy;
    logic [31:0] pts [4];
    logic        e;
    pts = '{32'h000a1234, 32'h000b0000, 32'h000b8000, 32'h000c0000};
    reg_wr(1'b1, vdcw_pkg::MISC_WR_PORT, 8'h00);
    host.cycle(1'b0, 1'b0, 32'h000a1234, 8'h00, 1'b0);
    check("closed window claim", 32'h0, {31'h0, claim});
    host.cycle(1'b0, 1'b0, 32'h10000000, 8'h00, 1'b1);
    check("linear buffer claim", 32'h1, {31'h0, claim});
    reg_wr(1'b1, vdcw_pkg::MISC_WR_PORT, 8'h02);
    for (int m = 0; m < 4; m++) begin
      gr_wr(vdcw_pkg::IDX_FRAME_MAP, {4'h0, 2'(m), 2'h0});
      for (int i = 0; i < 4; i++) begin
        e = in_map(2'(m), pts[i]);
        host.cycle(1'b0, 1'b0, pts[i], 8'h00, 1'b0);
        check("map hit", {31'h0, e}, {31'h0, legacy_hit});
        check("map claim", {31'h0, e}, {31'h0, claim});
      end
    end
    // linear mapping widens the color-only map back to the whole window
    gr_wr(vdcw_pkg::IDX_ADDR_MAP, 8'h02);
    host.cycle(1'b0, 1'b0, 32'h000a1234, 8'h00, 1'b0);
    check("linear map hit", 32'h1, {31'h0, legacy_hit});
  endtask

  task automatic t_page;
    gr_wr(vdcw_pkg::IDX_ADDR_MAP, 8'h11);
    host.cycle(1'b0, 1'b0, 32'h000a1234, 8'h00, 1'b0);
    check("page hit", 32'h1, {31'h0, page_hit});
    check("cache page addr", 32'h005a1234, {8'h0, page_addr});
    gr_wr(vdcw_pkg::IDX_ADDR_MAP, 8'h01);
    host.cycle(1'b0, 1'b0, 32'h000a1234, 8'h00, 1'b0);
    check("vga page addr", 32'h00001234, {8'h0, page_addr});
    host.cycle(1'b0, 1'b0, 32'h000b0000, 8'h00, 1'b0);
    check("page miss", 32'h0, {31'h0, page_hit});
  endtask

  task automatic finish_test;
    if (n_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    n_errors = 0;
    n_compared = 0;
    clock_in = 1'b0;
    rst_in = 1'b1;
    repeat (5) @(negedge clock_in);
    rst_in = 1'b0;
    t_reset();
    t_index();
    t_gfx_regs();
    t_misc();
    t_mmio();
    t_legacy();
    t_page();
    finish_test();
  end
endmodule

// file: verilog/vdcw_pkg.sv
// package: port addresses, indices, field layout and reset values of the display cache window regs
package vdcw_pkg;

  // ==========================================================================
  // i/o port addresses (memory offsets are the same values)
  // ==========================================================================
  localparam logic [15:0] MISC_WR_PORT  = 16'h03c2;
  localparam logic [15:0] MISC_RD_PORT  = 16'h03cc;
  localparam logic [15:0] INDEX_PORT    = 16'h03ce;
  localparam logic [15:0] DATA_PORT     = 16'h03cf;

  // ==========================================================================
  // graphics controller indices
  // ==========================================================================
  localparam int          IDX_W         = 5;
  localparam logic [4:0]  IDX_FRAME_MAP = 5'h06;
  localparam logic [4:0]  IDX_ADDR_MAP  = 5'h10;
  localparam logic [4:0]  IDX_PAGE_SEL  = 5'h11;
  localparam logic [7:0]  IDX_RD_MASK   = 8'h0f;

  // ==========================================================================
  // field layout and writable masks
  // ==========================================================================
  localparam int          MISC_ACC_BIT  = 1;
  localparam logic [7:0]  MISC_MASK     = 8'h02;
  localparam int          MAP_MODE_LSB  = 2;
  localparam logic [7:0]  FRAME_MASK    = 8'h0c;
  localparam logic [7:0]  ADDR_MAP_MASK = 8'h1f;
  localparam int          AM_PAGE_EN    = 0;
  localparam int          AM_LINEAR     = 1;
  localparam int          AM_PACKED     = 2;
  localparam int          AM_MEMMAP     = 3;
  localparam int          AM_TO_CACHE   = 4;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0]  MISC_RST      = 8'h00;
  localparam logic [7:0]  FRAME_RST     = 8'h00;
  localparam logic [7:0]  ADDR_MAP_RST  = 8'h00;
  localparam logic [7:0]  PAGE_SEL_RST  = 8'h00;
  localparam logic [4:0]  INDEX_RST     = 5'h00;
  localparam logic [7:0]  READ_ZERO     = 8'h00;

  // ==========================================================================
  // legacy window ranges and memory map mode codes
  // ==========================================================================
  localparam logic [31:0] WIN_A_LO      = 32'h000a0000;
  localparam logic [31:0] WIN_A_HI      = 32'h000affff;
  localparam logic [31:0] WIN_MONO_LO   = 32'h000b0000;
  localparam logic [31:0] WIN_MONO_HI   = 32'h000b7fff;
  localparam logic [31:0] WIN_COLOR_LO  = 32'h000b8000;
  localparam logic [31:0] WIN_ALL_HI    = 32'h000bffff;
  localparam logic [1:0]  MAP_ALL       = 2'h0;
  localparam logic [1:0]  MAP_A         = 2'h1;
  localparam logic [1:0]  MAP_MONO      = 2'h2;
  localparam logic [1:0]  MAP_COLOR     = 2'h3;
  localparam int          PAGE_OFF_W    = 16;
  localparam logic [7:0]  PAGE_VGA_HI   = 8'h00;

endpackage

// file: verilog/vdcw_regs.sv
// display cache detect and diagnostic register bank with legacy window decode
// Overview of operation
// [RQ1] every register answers both on i/o cycles and on memory cycles relative to the mmio base.
// [RQ2] the memory offset of each register is the same value as its i/o port address.
// [RQ3] the index port at 3ceh picks which graphics register the data port at 3cfh reaches.
// [RQ4] the upper four bits of the index register always read back as zero.
// [RQ5] the misc output register is written at 3c2h, read at 3cch, and resets to 00h.
// [RQ6] with the legacy access bit clear no access to a0000h-bffffh is claimed.
// [RQ7] the legacy access bit never blocks linear frame buffer accesses elsewhere.
// [RQ8] the frame map register sits at data port index 06h and is readable and writable.
// [RQ9] frame map bits 3:2 choose which part of a0000h-bffffh holds the vga buffer.
// [RQ10] that choice applies in vga modes and in extended modes without a linear buffer.
// [RQ11] the address mapping register sits at index 10h, is read/write and resets to 00h.
// [RQ12] address mapping bit 4 sends paging to the vga buffer (0) or the display cache (1).
// [RQ13] address mapping bits 3, 2 and 1 select memory map, packed mode and linear mapping.
// [RQ14] address mapping bit 0 maps memory through the 64 KB page at a0000h-affffh.
// [RQ15] the page select register at index 11h picks the 64 KB display cache window.
// [RQ16] unimplemented indices read zero and ignore writes; reserved bits read zero.
`timescale 1ns/10ps
module vdcw_regs #(
  parameter int MMIO_AW = 19
) (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        cyc_valid_in,
  input  wire logic        cyc_io_in,
  input  wire logic        cyc_write_in,
  input  wire logic [31:0] cyc_addr_in,
  input  wire logic [7:0]  cyc_wdata_in,
  input  wire logic [31:0] mmio_base_in,
  input  wire logic        lfb_hit_in,
  output logic             rd_valid_out,
  output logic [7:0]       rd_data_out,
  output logic             claim_out,
  output logic             legacy_hit_out,
  output logic             page_hit_out,
  output logic [23:0]      page_addr_out,
  output logic             legacy_en_out,
  output logic             memmap_sel_out,
  output logic             packed_en_out,
  output logic             linear_en_out
);

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  if (MMIO_AW < 16 || MMIO_AW > 31) begin : g_bad_aw
    $error("vdcw_regs: MMIO_AW must lie in 16..31");
  end

  // ==========================================================================
  // decode
  // ==========================================================================
  function automatic logic is_port(input logic [15:0] off, input logic [15:0] port);
    is_port = (off == port);
  endfunction

  logic [7:0]  misc_r;
  logic [7:0]  misc_nxt;
  logic [4:0]  index_r;
  logic [4:0]  index_nxt;
  logic [7:0]  frame_r;
  logic [7:0]  frame_nxt;
  logic [7:0]  amap_r;
  logic [7:0]  amap_nxt;
  logic [7:0]  page_sel_r;
  logic [7:0]  page_sel_nxt;

  // the base is aligned to the window; offsets above 16 bits hit nothing
  wire logic        mmio_win  = (cyc_addr_in[31:MMIO_AW] == mmio_base_in[31:MMIO_AW]) &&
                                (cyc_addr_in[MMIO_AW-1:16] == '0);
  wire logic        acc_io    = cyc_valid_in && cyc_io_in && (cyc_addr_in[31:16] == '0);
  wire logic        acc_mm    = cyc_valid_in && !cyc_io_in && mmio_win;    // RQ1
  wire logic        acc_reg   = acc_io || acc_mm;
  // same offset for both spaces, so one decode serves both
  wire logic [15:0] reg_off   = cyc_addr_in[15:0];                         // RQ2
  wire logic        hit_mwr   = acc_reg && is_port(reg_off, vdcw_pkg::MISC_WR_PORT);
  wire logic        hit_mrd   = acc_reg && is_port(reg_off, vdcw_pkg::MISC_RD_PORT);
  wire logic        hit_idx   = acc_reg && is_port(reg_off, vdcw_pkg::INDEX_PORT);
  wire logic        hit_dat   = acc_reg && is_port(reg_off, vdcw_pkg::DATA_PORT);
  wire logic        hit_any   = hit_mwr || hit_mrd || hit_idx || hit_dat;
  wire logic        wr_cyc    = cyc_write_in;
  wire logic        rd_cyc    = !cyc_write_in;

  wire logic        sel_frame = (index_r == vdcw_pkg::IDX_FRAME_MAP);      // RQ3
  wire logic        sel_amap  = (index_r == vdcw_pkg::IDX_ADDR_MAP);
  wire logic        sel_page  = (index_r == vdcw_pkg::IDX_PAGE_SEL);
  wire logic        wr_dat    = hit_dat && wr_cyc;

  // ==========================================================================
  // register next values
  // ==========================================================================
  // misc output is write-only at its write port; the read port ignores writes
  assign misc_nxt     = (hit_mwr && wr_cyc) ? (cyc_wdata_in & vdcw_pkg::MISC_MASK)
                                            : misc_r;                      // RQ5
  // bit 4 is kept hidden so indices 10h and 11h stay reachable
  assign index_nxt    = (hit_idx && wr_cyc) ? cyc_wdata_in[vdcw_pkg::IDX_W-1:0]
                                            : index_r;                     // RQ3
  assign frame_nxt    = (wr_dat && sel_frame) ? (cyc_wdata_in & vdcw_pkg::FRAME_MASK)
                                              : frame_r;                   // RQ8
  assign amap_nxt     = (wr_dat && sel_amap) ? (cyc_wdata_in & vdcw_pkg::ADDR_MAP_MASK)
                                             : amap_r;                     // RQ11
  assign page_sel_nxt = (wr_dat && sel_page) ? cyc_wdata_in : page_sel_r;  // RQ15

  // ==========================================================================
  // read data
  // ==========================================================================
  wire logic [7:0] idx_rd   = {3'h0, index_r} & vdcw_pkg::IDX_RD_MASK;    // RQ4
  wire logic [7:0] dat_rd   = sel_frame ? frame_r  :
                              sel_amap  ? amap_r   :
                              sel_page  ? page_sel_r : vdcw_pkg::READ_ZERO; // RQ16
  wire logic [7:0] rd_nxt   = !rd_cyc  ? vdcw_pkg::READ_ZERO :
                              hit_mrd  ? misc_r    :                       // RQ5
                              hit_idx  ? idx_rd    :
                              hit_dat  ? dat_rd    : vdcw_pkg::READ_ZERO;

  // ==========================================================================
  // window decode
  // ==========================================================================
  logic        leg_hit;
  logic        pg_hit;
  logic [23:0] pg_addr;
  // register space wins over the legacy window when both would match
  wire logic   mem_cyc = cyc_valid_in && !cyc_io_in && !acc_mm;

  vdcw_window_decode u_win (
    .addr_in          (cyc_addr_in),
    .mem_cyc_in       (mem_cyc),
    .legacy_en_in     (misc_r[vdcw_pkg::MISC_ACC_BIT]),
    .map_mode_in      (frame_r[vdcw_pkg::MAP_MODE_LSB +: 2]),
    .linear_en_in     (amap_r[vdcw_pkg::AM_LINEAR]),
    .page_en_in       (amap_r[vdcw_pkg::AM_PAGE_EN]),
    .page_to_cache_in (amap_r[vdcw_pkg::AM_TO_CACHE]),
    .page_sel_in      (page_sel_r),
    .legacy_hit_out   (leg_hit),
    .page_hit_out     (pg_hit),
    .page_addr_out    (pg_addr)
  );

  // linear buffer hits come from outside and bypass the legacy enable
  wire logic lfb_claim = cyc_valid_in && !cyc_io_in && lfb_hit_in;         // RQ7
  wire logic claim_nxt = hit_any || leg_hit || pg_hit || lfb_claim;

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      misc_r     <= vdcw_pkg::MISC_RST;
      index_r    <= vdcw_pkg::INDEX_RST;
      frame_r    <= vdcw_pkg::FRAME_RST;
      amap_r     <= vdcw_pkg::ADDR_MAP_RST;
      page_sel_r <= vdcw_pkg::PAGE_SEL_RST;
    end else begin
      misc_r     <= misc_nxt;
      index_r    <= index_nxt;
      frame_r    <= frame_nxt;
      amap_r     <= amap_nxt;
      page_sel_r <= page_sel_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_valid_out   <= 1'b0;
      rd_data_out    <= vdcw_pkg::READ_ZERO;
      claim_out      <= 1'b0;
      legacy_hit_out <= 1'b0;
      page_hit_out   <= 1'b0;
      page_addr_out  <= '0;
    end else begin
      rd_valid_out   <= hit_any && rd_cyc;
      rd_data_out    <= rd_nxt;
      claim_out      <= claim_nxt;                                         // RQ6
      legacy_hit_out <= leg_hit;
      page_hit_out   <= pg_hit;                                            // RQ14
      page_addr_out  <= pg_addr;
    end
  end

  // mode bits are copies of the live register; a write shows on the same edge as in the register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      legacy_en_out  <= 1'b0;
      memmap_sel_out <= 1'b0;
      packed_en_out  <= 1'b0;
      linear_en_out  <= 1'b0;
    end else begin
      legacy_en_out  <= misc_nxt[vdcw_pkg::MISC_ACC_BIT];
      memmap_sel_out <= amap_nxt[vdcw_pkg::AM_MEMMAP];                     // RQ13
      packed_en_out  <= amap_nxt[vdcw_pkg::AM_PACKED];                     // RQ13
      linear_en_out  <= amap_nxt[vdcw_pkg::AM_LINEAR];                     // RQ13
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  wire logic [31:0] mm_idx_addr = {mmio_base_in[31:16], vdcw_pkg::INDEX_PORT};

  sequence s_mm_index_wr;
    cyc_valid_in && !cyc_io_in && cyc_write_in && (cyc_addr_in == mm_idx_addr);
  endsequence

  sequence s_io_index_rd;
    cyc_valid_in && cyc_io_in && !cyc_write_in &&
    (cyc_addr_in == {16'h0000, vdcw_pkg::INDEX_PORT});
  endsequence

  sequence s_blocked_legacy;
    cyc_valid_in && !cyc_io_in && !acc_mm && !misc_r[vdcw_pkg::MISC_ACC_BIT] &&
    (cyc_addr_in >= vdcw_pkg::WIN_A_LO) && (cyc_addr_in <= vdcw_pkg::WIN_ALL_HI);
  endsequence

  // reset is the trigger here, so the default disable must not swallow it
  property p_reset_misc;
    @(posedge clock_in) disable iff (1'b0)
      rst_in |=> (misc_r == vdcw_pkg::MISC_RST) && !legacy_en_out;
  endproperty

  a_misc_reset_zero: assert property (p_reset_misc) // RQ5
    else $error("misc output not zero after reset");

  a_index_upper_zero: assert property (s_io_index_rd |=> rd_valid_out && // RQ4
                                       (rd_data_out[7:4] == 4'h0))
    else $error("index upper bits not zero on read");

  a_mmio_io_mirror: assert property (s_mm_index_wr ##2 s_io_index_rd |=> // RQ2
                                     rd_data_out[3:0] == $past(cyc_wdata_in[3:0], 3))
    else $error("memory index write not seen at i/o port");

  a_legacy_blocked: assert property ((s_blocked_legacy and !lfb_hit_in) |=> // RQ6
                                     !claim_out && !legacy_hit_out && !page_hit_out)
    else $error("legacy window claimed while disabled");

  a_lfb_not_blocked: assert property (cyc_valid_in && !cyc_io_in && lfb_hit_in |=> // RQ7
                                      claim_out)
    else $error("linear buffer access not claimed");

  a_map_mode_color: assert property (cyc_valid_in && !cyc_io_in && !acc_mm && // RQ9
                                     !amap_r[vdcw_pkg::AM_LINEAR] &&
                                     frame_r[vdcw_pkg::MAP_MODE_LSB +: 2] == vdcw_pkg::MAP_COLOR &&
                                     cyc_addr_in == vdcw_pkg::WIN_MONO_LO |=> !legacy_hit_out)
    else $error("mono range hit in color map mode");

  a_page_translate: assert property ( // RQ15
    page_hit_out && $past(amap_r[vdcw_pkg::AM_TO_CACHE]) |->
    page_addr_out[23:16] == $past(page_sel_r))
    else $error("page address not built from page select");

  a_unimpl_write: assert property (wr_dat && !sel_frame && !sel_amap && !sel_page |=> // RQ16
                                   $stable(frame_r) && $stable(amap_r) && $stable(page_sel_r)
                                   && $stable(misc_r) && $stable(index_r))
    else $error("unimplemented index write changed state");

  a_amap_readback: assert property (wr_dat && sel_amap ##2 hit_dat && rd_cyc && sel_amap |=> // RQ11
                                    rd_data_out == ($past(cyc_wdata_in, 3) &
                                                    vdcw_pkg::ADDR_MAP_MASK))
    else $error("address mapping readback mismatch");

  sequence s_io_misc_rd_port_wr;
    cyc_valid_in && cyc_io_in && cyc_write_in &&
    (cyc_addr_in == {16'h0000, vdcw_pkg::MISC_RD_PORT});
  endsequence

  a_misc_rdport_ro: assert property (s_io_misc_rd_port_wr |=> $stable(misc_r)) // RQ5
    else $error("misc output changed by write at read port");

  a_data_read_answer: assert property (cyc_valid_in && cyc_io_in && !cyc_write_in && // RQ3
                                       cyc_addr_in == {16'h0000, vdcw_pkg::DATA_PORT} |=>
                                       rd_valid_out && claim_out)
    else $error("data port read not answered");

  a_write_no_rdata: assert property (cyc_valid_in && cyc_write_in |=> // RQ1
                                     !rd_valid_out && (rd_data_out == vdcw_pkg::READ_ZERO))
    else $error("write cycle raised read data");

  a_mm_index_claim: assert property (s_mm_index_wr |=> claim_out) // RQ1
    else $error("memory mapped index write not claimed");

  a_mode_copies: assert property ((memmap_sel_out == amap_r[vdcw_pkg::AM_MEMMAP]) && // RQ13
                                  (packed_en_out == amap_r[vdcw_pkg::AM_PACKED]) &&
                                  (linear_en_out == amap_r[vdcw_pkg::AM_LINEAR]) &&
                                  (legacy_en_out == misc_r[vdcw_pkg::MISC_ACC_BIT]))
    else $error("mode outputs differ from registers");

  a_reserved_zero: assert property ( // RQ16
    ((frame_r & ~vdcw_pkg::FRAME_MASK) == vdcw_pkg::READ_ZERO) &&
    ((amap_r & ~vdcw_pkg::ADDR_MAP_MASK) == vdcw_pkg::READ_ZERO) &&
    ((misc_r & ~vdcw_pkg::MISC_MASK) == vdcw_pkg::READ_ZERO))
    else $error("reserved register bits not zero");

  a_page_to_vga: assert property ( // RQ12
    page_hit_out && !$past(amap_r[vdcw_pkg::AM_TO_CACHE]) |->
    page_addr_out[23:16] == vdcw_pkg::PAGE_VGA_HI)
    else $error("vga page address carries page select");

  a_unimpl_read: assert property ( // RQ16
    hit_dat && rd_cyc && !sel_frame && !sel_amap && !sel_page |=>
    rd_data_out == vdcw_pkg::READ_ZERO)
    else $error("unimplemented index read not zero");

endmodule

// file: verilog/vdcw_window_decode.sv
// window decoder: legacy window claim and 64 KB page translation
`timescale 1ns/10ps
module vdcw_window_decode (
  input  wire logic [31:0] addr_in,
  input  wire logic        mem_cyc_in,
  input  wire logic        legacy_en_in,
  input  wire logic [1:0]  map_mode_in,
  input  wire logic        linear_en_in,
  input  wire logic        page_en_in,
  input  wire logic        page_to_cache_in,
  input  wire logic [7:0]  page_sel_in,
  output logic             legacy_hit_out,
  output logic             page_hit_out,
  output logic [23:0]      page_addr_out
);

  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  wire logic in_all   = in_rng(addr_in, vdcw_pkg::WIN_A_LO, vdcw_pkg::WIN_ALL_HI);
  wire logic in_a     = in_rng(addr_in, vdcw_pkg::WIN_A_LO, vdcw_pkg::WIN_A_HI);
  wire logic in_mono  = in_rng(addr_in, vdcw_pkg::WIN_MONO_LO, vdcw_pkg::WIN_MONO_HI);
  wire logic in_color = in_rng(addr_in, vdcw_pkg::WIN_COLOR_LO, vdcw_pkg::WIN_ALL_HI);

  // mode narrowing only holds while no linear frame buffer is in use
  wire logic in_mode =
    linear_en_in                             ? in_all   : // RQ10
    (map_mode_in == vdcw_pkg::MAP_ALL)       ? in_all   : // RQ9
    (map_mode_in == vdcw_pkg::MAP_A)         ? in_a     :
    (map_mode_in == vdcw_pkg::MAP_MONO)      ? in_mono  : in_color;

  // nothing in a0000h-bffffh is claimed while access is disabled
  assign legacy_hit_out = mem_cyc_in && legacy_en_in && in_mode;     // RQ6
  assign page_hit_out   = mem_cyc_in && legacy_en_in && page_en_in && in_a; // RQ14
  assign page_addr_out  = page_to_cache_in ?
    {page_sel_in, addr_in[vdcw_pkg::PAGE_OFF_W-1:0]} :              // RQ12 RQ15
    {vdcw_pkg::PAGE_VGA_HI, addr_in[vdcw_pkg::PAGE_OFF_W-1:0]};

endmodule
